// ===== design/deh_pkg.sv
// constants shared by the drive error history object bank
package deh_pkg;

  // ------------------------------------------------------------------
  // object indices
  // ------------------------------------------------------------------
  localparam logic [15:0] IDX_DEVICE_TYPE   = 16'h1000;
  localparam logic [15:0] IDX_ERROR_FLAGS   = 16'h1001;
  localparam logic [15:0] IDX_VENDOR_STATUS = 16'h1002;
  localparam logic [15:0] IDX_HISTORY       = 16'h1003;
  localparam logic [7:0]  SUB_ZERO          = 8'h00;
  localparam logic [7:0]  SUB_FIRST_SLOT    = 8'h01;

  // ------------------------------------------------------------------
  // device type word layout
  // ------------------------------------------------------------------
  localparam logic [15:0] PROFILE_NUMBER    = 16'h0192;
  localparam int          DEVTYPE_INFO_LSB  = 16;
  localparam int          DEVTYPE_PROF_LSB  = 0;

  // ------------------------------------------------------------------
  // error class flag bit positions
  // ------------------------------------------------------------------
  localparam int FLAG_GENERIC_BIT  = 0;
  localparam int FLAG_CURRENT_BIT  = 1;
  localparam int FLAG_VOLTAGE_BIT  = 2;
  localparam int FLAG_TEMP_BIT     = 3;
  localparam int FLAG_COMM_BIT     = 4;
  localparam int FLAG_PROFILE_BIT  = 5;
  localparam int FLAG_RESERVED_BIT = 6;
  localparam int FLAG_VENDOR_BIT   = 7;
  localparam logic [7:0] FLAG_RESERVED_MASK = 8'h40;

  // ------------------------------------------------------------------
  // history stack geometry and entry layout
  // ------------------------------------------------------------------
  localparam int          STACK_DEPTH      = 15;
  localparam logic [3:0]  STACK_DEPTH_CNT  = 4'hf;
  localparam int          ENTRY_VENDOR_LSB = 24;
  localparam int          ENTRY_FLAGS_LSB  = 16;
  localparam int          ENTRY_CODE_LSB   = 0;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [3:0]  COUNT_RESET = 4'h0;
  localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;

  // ------------------------------------------------------------------
  // transfer abort codes
  // ------------------------------------------------------------------
  localparam logic [31:0] ABORT_NONE        = 32'h0000_0000;
  localparam logic [31:0] ABORT_NO_DATA     = 32'h0800_0024;
  localparam logic [31:0] ABORT_BAD_VALUE   = 32'h0609_0030;
  localparam logic [31:0] ABORT_NO_SUBINDEX = 32'h0609_0011;
  localparam logic [31:0] ABORT_READ_ONLY   = 32'h0601_0002;
  localparam logic [31:0] ABORT_NO_OBJECT   = 32'h0602_0000;

endpackage : deh_pkg

// ===== design/deh_error_history.sv
// error reporting objects of a drive: device type, error flags, vendor status, history
`timescale 1ns/1ps
module deh_error_history #(
  parameter logic [15:0] DEVTYPE_ADD_INFO = 16'h0000  // arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // object access requests from the network side
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [15:0] req_index,
  input  wire logic [7:0]  req_subindex,
  input  wire logic [31:0] req_wdata,
  output logic             resp_valid,
  output logic             resp_abort,
  output logic [31:0]      resp_abort_code,
  output logic [31:0]      resp_rdata,
  // error events from the drive
  input  wire logic        err_valid,
  input  wire logic [15:0] err_code,
  input  wire logic [7:0]  err_vendor_code,
  input  wire logic [7:0]  err_class,
  input  wire logic [7:0]  err_class_clear,
  // vendor status source
  input  wire logic [31:0] vendor_status,
  // state seen by the drive
  output logic [7:0]       error_flags,
  output logic [3:0]       error_count
);

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  // true when the sub-index addresses the object itself
  function automatic logic is_sub0(input logic [7:0] sub);
    is_sub0 = (sub == deh_pkg::SUB_ZERO);
  endfunction : is_sub0

  // true when the sub-index names a slot holding a recorded entry
  function automatic logic slot_filled(input logic [7:0] sub, input logic [3:0] cnt);
    slot_filled = (sub >= deh_pkg::SUB_FIRST_SLOT) && (sub <= {4'h0, cnt});
  endfunction : slot_filled

  // true for the three single-word objects, which share one access pattern
  function automatic logic is_word_object(input logic [15:0] idx);
    is_word_object = (idx == deh_pkg::IDX_DEVICE_TYPE)
                     || (idx == deh_pkg::IDX_ERROR_FLAGS)
                     || (idx == deh_pkg::IDX_VENDOR_STATUS);
  endfunction : is_word_object

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  // stored state
  logic [7:0]  flags_reg;
  logic [7:0]  flags_next;
  logic [3:0]  count_reg;
  logic [3:0]  count_next;
  logic [31:0] stack_reg  [0:deh_pkg::STACK_DEPTH-1];
  logic [31:0] stack_next [0:deh_pkg::STACK_DEPTH-1];
  // registered answer
  logic        resp_valid_reg;
  logic        resp_valid_next;
  logic        resp_abort_reg;
  logic        resp_abort_next;
  logic [31:0] resp_code_reg;
  logic [31:0] resp_code_next;
  logic [31:0] resp_rdata_reg;
  logic [31:0] resp_rdata_next;
  // combinational helpers
  logic [31:0] devtype_word;
  logic [31:0] new_entry;
  logic        hist_sub0_write;
  logic        clear_hit;
  logic [3:0]  slot_idx;

  // ------------------------------------------------------------------
  // constant device type word
  // ------------------------------------------------------------------
  always_comb
  begin
    devtype_word = 32'h0000_0000;
    devtype_word[deh_pkg::DEVTYPE_INFO_LSB +: 16] = DEVTYPE_ADD_INFO;
    devtype_word[deh_pkg::DEVTYPE_PROF_LSB +: 16] = deh_pkg::PROFILE_NUMBER;
  end

  // ------------------------------------------------------------------
  // error class flags
  // ------------------------------------------------------------------
  // clear first, then set, so an event in the clearing cycle survives
  always_comb
  begin
    flags_next = flags_reg & ~err_class_clear;
    if (err_valid)
    begin
      flags_next = flags_next | err_class;
      flags_next[deh_pkg::FLAG_GENERIC_BIT] = 1'b1;
    end
    flags_next = flags_next & ~deh_pkg::FLAG_RESERVED_MASK;
  end

  // flag register; only a reset or the clear port lowers a bit
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      flags_reg <= deh_pkg::FLAGS_RESET;
    else
      flags_reg <= flags_next;
  end

  // ------------------------------------------------------------------
  // history stack
  // ------------------------------------------------------------------
  // entry carries the flags as they stand after this event
  always_comb
  begin
    new_entry = deh_pkg::ENTRY_RESET;
    new_entry[deh_pkg::ENTRY_VENDOR_LSB +: 8] = err_vendor_code;
    new_entry[deh_pkg::ENTRY_FLAGS_LSB +: 8]  = flags_next;
    new_entry[deh_pkg::ENTRY_CODE_LSB +: 16]  = err_code;
  end

  // only a zero written to sub-index 0 of the history empties it
  assign hist_sub0_write = req_valid && req_write && (req_index == deh_pkg::IDX_HISTORY)
                           && is_sub0(req_subindex);
  assign clear_hit = hist_sub0_write && (req_wdata == 32'h0000_0000);

  // shift network; a clear and a new error together leave just the new one
  // limitation: only fifteen slots are kept, older entries drop silently
  generate
    for (genvar i = 0; i < deh_pkg::STACK_DEPTH; i++)
    begin : g_slot
      if (i == 0)
      begin : g_head
        // a new error beats a clear so the fresh entry is never lost
        always_comb
        begin
          if (err_valid)
            stack_next[i] = new_entry;
          else if (clear_hit)
            stack_next[i] = deh_pkg::ENTRY_RESET;
          else
            stack_next[i] = stack_reg[i];
        end
      end
      else
      begin : g_tail
        // a clear empties every older slot, even while an error arrives
        always_comb
        begin
          if (clear_hit)
            stack_next[i] = deh_pkg::ENTRY_RESET;
          else if (err_valid)
            stack_next[i] = stack_reg[i-1];
          else
            stack_next[i] = stack_reg[i];
        end
      end

      // slot flop; reset zeroes it so no stale entry reads back
      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          stack_reg[i] <= deh_pkg::ENTRY_RESET;
        else
          stack_reg[i] <= stack_next[i];
      end
    end
  endgenerate

  // recorded count, saturating so it never names an unreadable slot
  always_comb
  begin
    count_next = clear_hit ? deh_pkg::COUNT_RESET : count_reg;
    if (err_valid && (count_next != deh_pkg::STACK_DEPTH_CNT))
      count_next = count_next + 4'h1;
  end

  // count flop
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      count_reg <= deh_pkg::COUNT_RESET;
    else
      count_reg <= count_next;
  end

  // ------------------------------------------------------------------
  // object access answers
  // ------------------------------------------------------------------
  // answers reflect state before the request's own effect
  assign slot_idx = 4'(req_subindex - deh_pkg::SUB_FIRST_SLOT);

  always_comb
  begin
    resp_valid_next = req_valid;
    resp_abort_next = 1'b0;
    resp_code_next  = deh_pkg::ABORT_NONE;
    resp_rdata_next = 32'h0000_0000;
    if (req_valid)
    begin
      // history: sub-index 0 is the count, the slots above it are read only
      if (req_index == deh_pkg::IDX_HISTORY)
      begin
        if (is_sub0(req_subindex))
        begin
          if (!req_write)
            resp_rdata_next = {28'h000_0000, count_reg};
          else if (req_wdata != 32'h0000_0000)
          begin
            resp_abort_next = 1'b1;
            resp_code_next  = deh_pkg::ABORT_BAD_VALUE;
          end
        end
        else if (req_write)
        begin
          resp_abort_next = 1'b1;
          resp_code_next  = deh_pkg::ABORT_READ_ONLY;
        end
        else if (count_reg == deh_pkg::COUNT_RESET)
        begin
          resp_abort_next = 1'b1;
          resp_code_next  = deh_pkg::ABORT_NO_DATA;
        end
        else if (slot_filled(req_subindex, count_reg))
          resp_rdata_next = stack_reg[slot_idx];
        else
        begin
          resp_abort_next = 1'b1;
          resp_code_next  = deh_pkg::ABORT_NO_SUBINDEX;
        end
      end
      // word objects: a bad sub-index is reported before a bad access kind
      else if (is_word_object(req_index))
      begin
        if (!is_sub0(req_subindex))
        begin
          resp_abort_next = 1'b1;
          resp_code_next  = deh_pkg::ABORT_NO_SUBINDEX;
        end
        else if (req_write)
        begin
          resp_abort_next = 1'b1;
          resp_code_next  = deh_pkg::ABORT_READ_ONLY;
        end
        else if (req_index == deh_pkg::IDX_DEVICE_TYPE)
          resp_rdata_next = devtype_word;
        else if (req_index == deh_pkg::IDX_ERROR_FLAGS)
          resp_rdata_next = {24'h00_0000, flags_reg};
        else
          resp_rdata_next = vendor_status;
      end
      // any other index lies outside this bank
      else
      begin
        resp_abort_next = 1'b1;
        resp_code_next  = deh_pkg::ABORT_NO_OBJECT;
      end
    end
  end

  // answer flops; the strobe drops back to zero one cycle after a request
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      resp_valid_reg <= 1'b0;
      resp_abort_reg <= 1'b0;
      resp_code_reg  <= deh_pkg::ABORT_NONE;
      resp_rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      resp_valid_reg <= resp_valid_next;
      resp_abort_reg <= resp_abort_next;
      resp_code_reg  <= resp_code_next;
      resp_rdata_reg <= resp_rdata_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from flops
  // ------------------------------------------------------------------
  // every output is a plain copy of a register, no logic after the flop
  assign resp_valid      = resp_valid_reg;
  assign resp_abort      = resp_abort_reg;
  assign resp_abort_code = resp_code_reg;
  assign resp_rdata      = resp_rdata_reg;
  assign error_flags     = flags_reg;
  assign error_count     = count_reg;

endmodule : deh_error_history

// ===== verification/deh_error_history_asserts.sv
// concurrent checks on the object access and error history ports
`timescale 1ns/1ps
module deh_error_history_asserts #(
  parameter logic [15:0] DEVTYPE_ADD_INFO = 16'h0000  // arbitrary value
) (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [15:0] req_index,
  input wire logic [7:0]  req_subindex,
  input wire logic [31:0] req_wdata,
  input wire logic        resp_abort,
  input wire logic [31:0] resp_abort_code,
  input wire logic [31:0] resp_rdata,
  input wire logic        err_valid,
  input wire logic [7:0]  err_class,
  input wire logic [31:0] vendor_status,
  input wire logic [7:0]  error_flags,
  input wire logic [3:0]  error_count
);
  // ------------------------------------------------------------------
  // port properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic rd;
  logic hist;
  // request decode shared by several properties
  assign rd   = req_valid && !req_write;
  assign hist = req_index == 16'h1003;
  flag_rsvd_a: assert property (error_flags[6] == 1'b0) else $error("reserved flag set");
  flag_set_a: assert property (
    err_valid |=> (error_flags & (($past(err_class) | 8'h01) & 8'hbf))
    == (($past(err_class) | 8'h01) & 8'hbf)) else $error("class flag not set");
  status_read_a: assert property (
    rd && req_index == 16'h1002 && req_subindex == 8'h00
    |=> !resp_abort && resp_rdata == $past(vendor_status)) else $error("status bad");
  empty_read_a: assert property (
    rd && hist && req_subindex != 8'h00 && error_count == 4'h0
    |=> resp_abort && resp_abort_code == 32'h0800_0024) else $error("empty read");
  count_step_a: assert property (
    err_valid && !req_valid |=> error_count ==
    (($past(error_count) == 4'hf) ? 4'hf : $past(error_count) + 4'h1))
    else $error("count step");
  hist_clear_a: assert property (
    req_valid && req_write && hist && req_subindex == 8'h00
    && req_wdata == 32'h0 && !err_valid |=> !resp_abort && error_count == 4'h0)
    else $error("clear failed");
  bad_clear_a: assert property (
    req_valid && req_write && hist && req_subindex == 8'h00
    && req_wdata != 32'h0 && !err_valid |=> resp_abort && resp_abort_code == 32'h0609_0030
    && $stable(error_count)) else $error("nonzero clear");
  count_read_a: assert property (
    rd && hist && req_subindex == 8'h00
    |=> resp_rdata == {28'h0, $past(error_count)}) else $error("count read");
  devtype_read_a: assert property (
    rd && req_index == 16'h1000 && req_subindex == 8'h00
    |=> resp_rdata == {DEVTYPE_ADD_INFO, 16'h0192}) else $error("device type");
endmodule : deh_error_history_asserts

bind deh_error_history deh_error_history_asserts #(.DEVTYPE_ADD_INFO(DEVTYPE_ADD_INFO)) u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid), .req_write(req_write),
  .req_index(req_index), .req_subindex(req_subindex), .req_wdata(req_wdata),
  .resp_abort(resp_abort), .resp_abort_code(resp_abort_code), .resp_rdata(resp_rdata),
  .err_valid(err_valid), .err_class(err_class), .vendor_status(vendor_status),
  .error_flags(error_flags), .error_count(error_count));

// ===== verification/deh_sdo_master.sv
// network master model issuing object access requests
`timescale 1ns/1ps
module deh_sdo_master (
  input wire logic        ref_clk,
  input wire logic        resp_valid,
  input wire logic        resp_abort,
  input wire logic [31:0] resp_abort_code,
  input wire logic [31:0] resp_rdata,
  output logic            req_valid,
  output logic            req_write,
  output logic [15:0]     req_index,
  output logic [7:0]      req_subindex,
  output logic [31:0]     req_wdata
);
  // ------------------------------------------------------------------
  // request driver
  // ------------------------------------------------------------------
  // idle fields toggle so a stale value is never mistaken for a request
  initial
  begin
    req_valid = 1'b0;
    {req_write, req_index, req_subindex, req_wdata} = '0;
  end
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, output logic [31:0] rd, output logic ab,
                      output logic [31:0] cd, output bit ok);
    ok = 1'b0;
    @(negedge ref_clk);
    req_valid    = 1'b1;
    req_write    = w;
    req_index    = idx;
    req_subindex = sub;
    req_wdata    = wd;
    @(negedge ref_clk);
    req_valid = 1'b0;
    {req_write, req_index, req_subindex, req_wdata} = ~{w, idx, sub, wd};
    // answer is due one edge after the request; allow a small margin
    for (int n = 0; n < 4 && !ok; n++)
    begin
      if (resp_valid === 1'b1)
      begin
        ok = 1'b1;
        rd = resp_rdata;
        ab = resp_abort;
        cd = resp_abort_code;
      end
      else
        @(negedge ref_clk);
    end
  endtask : xfer
endmodule : deh_sdo_master

// ===== verification/deh_error_history_test.sv
// self-checking bench for the drive error history objects
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module deh_error_history_test;
  // ------------------------------------------------------------------
  // bench signals and helpers
  // ------------------------------------------------------------------
  logic        ref_clk, rst_b, req_valid, req_write, resp_valid, resp_abort, err_valid, ab;
  logic [15:0] req_index, err_code;
  logic [7:0]  req_subindex, err_vendor_code, err_class, err_class_clear, error_flags, exp_f;
  logic [31:0] req_wdata, resp_abort_code, resp_rdata, vendor_status, rd, cd;
  logic [31:0] exp_e [0:15];
  logic [3:0]  error_count;
  int          fails, compares;
  bit          ok;
  deh_error_history #(.DEVTYPE_ADD_INFO(16'h3c3c)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
    .req_subindex(req_subindex), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_abort(resp_abort), .resp_abort_code(resp_abort_code), .resp_rdata(resp_rdata),
    .err_valid(err_valid), .err_code(err_code), .err_vendor_code(err_vendor_code),
    .err_class(err_class), .err_class_clear(err_class_clear), .vendor_status(vendor_status),
    .error_flags(error_flags), .error_count(error_count));
  deh_sdo_master u_master (.ref_clk(ref_clk), .resp_valid(resp_valid), .resp_abort(resp_abort),
    .resp_abort_code(resp_abort_code), .resp_rdata(resp_rdata), .req_valid(req_valid),
    .req_write(req_write), .req_index(req_index), .req_subindex(req_subindex),
    .req_wdata(req_wdata));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task complete_run;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  // a missing answer ends the run at once
  task xf(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
    u_master.xfer(w, idx, sub, wd, rd, ab, cd, ok);
    if (!ok)
    begin
      fails++;
      complete_run();
    end
  endtask : xf
  task raise(input logic [7:0] cls, input int i);
    @(negedge ref_clk);
    err_valid       = 1'b1;
    err_class       = cls;
    err_code        = 16'h1000 + 16'(i);
    err_vendor_code = 8'(i);
    @(negedge ref_clk);
    err_valid = 1'b0;
  endtask : raise
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task t_empty;
    xf(1'b0, 16'h1003, 8'h00, 32'h0);
    `CHK("count", 32'h0, rd)
    xf(1'b0, 16'h1003, 8'h01, 32'h0);
    `CHK("empty abort", 32'h0800_0024, cd)
    $display("done empty");
  endtask : t_empty
  task t_ident;
    xf(1'b0, 16'h1000, 8'h00, 32'h0);
    `CHK("device type", 32'h3c3c_0192, rd)
    xf(1'b0, 16'h1002, 8'h00, 32'h0);
    `CHK("status", 32'h5a5a_0f0f, rd)
    xf(1'b1, 16'h1002, 8'h00, 32'h0000_1111);
    `CHK("status write", 32'h0601_0002, cd)
    xf(1'b0, 16'h1001, 8'h01, 32'h0);
    `CHK("sub abort", 32'h0609_0011, cd)
    xf(1'b0, 16'h2000, 8'h00, 32'h0);
    `CHK("no object", 32'h0602_0000, cd)
    $display("done ident");
  endtask : t_ident
  // sixteen errors, one class each, overflow the fifteen slots
  task t_fill;
    exp_f = 8'h00;
    for (int i = 0; i < 16; i++)
    begin
      raise(8'h01 << (i % 8), i);
      exp_f = (exp_f | (8'h01 << (i % 8)) | 8'h01) & 8'hbf;
      exp_e[i] = {8'(i), exp_f, 16'h1000 + 16'(i)};
      `CHK("flags", exp_f, error_flags)
      `CHK("count", 4'((i < 15) ? i + 1 : 15), error_count)
    end
    xf(1'b0, 16'h1001, 8'h00, 32'h0);
    `CHK("flag read", {24'h0, exp_f}, rd)
    for (int s = 1; s < 16; s++)
    begin
      xf(1'b0, 16'h1003, 8'(s), 32'h0);
      `CHK("slot", exp_e[16 - s], rd)
    end
    $display("done fill");
  endtask : t_fill
  task t_clear;
    xf(1'b0, 16'h1003, 8'h10, 32'h0);
    `CHK("past slots", 32'h0609_0011, cd)
    xf(1'b1, 16'h1003, 8'h01, 32'h0000_0001);
    `CHK("slot write", 32'h0601_0002, cd)
    xf(1'b1, 16'h1003, 8'h00, 32'h0000_0001);
    `CHK("bad clear", 32'h0609_0030, cd)
    `CHK("abort flag", 1'b1, ab)
    `CHK("kept count", 4'hf, error_count)
    xf(1'b0, 16'h1003, 8'h01, 32'h0);
    `CHK("kept slot", exp_e[15], rd)
    xf(1'b1, 16'h1003, 8'h00, 32'h0);
    `CHK("clear abort", 1'b0, ab)
    `CHK("cleared", 4'h0, error_count)
    xf(1'b0, 16'h1003, 8'h01, 32'h0);
    `CHK("after clear", 32'h0800_0024, cd)
    @(negedge ref_clk);
    err_class_clear = 8'hff;
    @(negedge ref_clk);
    err_class_clear = 8'h00;
    `CHK("flags clear", 8'h00, error_flags)
    $display("done clear");
  endtask : t_clear
  // clear write and new error in one cycle, then a flag clear against a new event
  task t_both;
    fork
      xf(1'b1, 16'h1003, 8'h00, 32'h0);
      raise(8'h04, 32);
    join
    `CHK("clear and error", 4'h1, error_count)
    xf(1'b0, 16'h1003, 8'h01, 32'h0);
    `CHK("fresh entry", 32'h2005_1020, rd)
    fork
      raise(8'h08, 33);
      begin
        @(negedge ref_clk);
        err_class_clear = 8'hff;
        @(negedge ref_clk);
        err_class_clear = 8'h00;
      end
    join
    `CHK("set beats clear", 8'h09, error_flags)
    $display("done both");
  endtask : t_both
  // reset in mid-run empties the history and drops the flags
  task t_reset;
    @(negedge ref_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    `CHK("reset count", 4'h0, error_count)
    `CHK("reset flags", 8'h00, error_flags)
    `CHK("reset answer", 1'b0, resp_valid)
    xf(1'b0, 16'h1003, 8'h01, 32'h0);
    `CHK("reset slots", 32'h0800_0024, cd)
    $display("done reset");
  endtask : t_reset
  // main sequence: inputs set at time zero, reset for five cycles
  initial
  begin
    rst_b = 1'b0;
    {err_valid, err_code, err_vendor_code, err_class, err_class_clear} = '0;
    vendor_status = 32'h5a5a_0f0f;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    t_empty();
    t_ident();
    t_fill();
    t_clear();
    t_both();
    t_reset();
    complete_run();
  end
endmodule : deh_error_history_test
